// ==== flash_host_defines.svh ====
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// ============================================================
// Command codes written into the device's command latch
`define CMD_READ_ARRAY      8'h00
`define CMD_READ_IDENT      8'h90
`define CMD_ERASE           8'h20
`define CMD_ERASE_CHECK     8'hA0
`define CMD_PROGRAM         8'h40
`define CMD_PROGRAM_CHECK   8'hC0
`define CMD_RESET           8'hFF

// ============================================================
// Readback meaning a fully erased byte
`define ERASED_BYTE         8'hFF

// ============================================================
// Bus timing, in ns, and derived counts at the 50 ns clock
`define CLK_PERIOD_NS       50
`define T_SETUP_NS          100
`define T_STROBE_NS         100
`define T_HOLD_NS           50
`define T_ACCESS_NS         150
`define SETUP_CYC   ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC  ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC    ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Read waits access time plus three synchroniser stages
`define ACCESS_CYC  (((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) + 3)

`endif

// ==== flash_host_pkg.sv ====
`default_nettype none

package flash_host_pkg;

    // Operations the user may request
    typedef enum logic [2:0]
    {
        OP_READ,
        OP_READ_ID,
        OP_ERASE,
        OP_ERASE_CHECK,
        OP_PROGRAM,
        OP_PROGRAM_CHECK,
        OP_RESET
    } op_t;

    // Bus sequencer phases
    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_READ,
        ST_FINISH
    } phase_t;

endpackage

`default_nettype wire

// ==== flash_host.sv ====
// What this block does
// - Reads drive chip select and output gate low together to get data.
// - After writing 90H, reads at 0000H and 0001H return identifier codes.
// - Write is strobe low with chip select low; address at fall, data at rise.
// - Chip erase is two consecutive writes of 20H.
// - Programming is 40H then a write of target address and data.
// - Erase verify writes A0H with address; next read gives verify data.
// - Program verify writes C0H with no address; next read checks last byte.
// - Reset is two writes of FFH, then a defined command must follow.
// - Erase verify readback of FFH means byte erased, else erase again; the host only flags erased_r and never repeats the erase itself.
`include "flash_host_defines.svh"
`default_nettype none

module flash_host
#(
    parameter int ADDR_W = 18
)
(
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   nrst,
    // User request port
    input  wire logic                   req_valid,
    input  wire flash_host_pkg::op_t    req_op,
    input  wire logic [ADDR_W-1:0]      req_addr,
    input  wire logic [7:0]             req_data,
    input  wire logic                   supply_request,
    input  wire logic                   supply_ok,
    // User answer port
    output logic                        busy_r,
    output logic                        done_r,
    output logic                        refused_r,
    output logic [7:0]                  rdata_r,
    output logic                        erased_r,
    // Device pins
    output logic                        supply_en_r,
    output logic                        chip_sel_n_r,
    output logic                        out_gate_n_r,
    output logic                        write_n_r,
    output logic [ADDR_W-1:0]           addr_r,
    output logic [7:0]                  dq_out_r,
    output logic                        dq_oe_r,
    input  wire logic [7:0]             dq_in
);
    import flash_host_pkg::*;
    localparam logic [7:0] SETUP_N  = 8'(`SETUP_CYC);
    localparam logic [7:0] STROBE_N = 8'(`STROBE_CYC);
    localparam logic [7:0] HOLD_N   = 8'(`HOLD_CYC);
    localparam logic [7:0] ACCESS_N = 8'(`ACCESS_CYC);
    // ============================================================
    // State
    typedef struct packed {
        phase_t             phase;
        op_t                op;
        logic               step;
        logic [7:0]         cnt;
        logic [ADDR_W-1:0]  uaddr;
        logic [7:0]         udata;
        logic [7:0]         s1;
        logic [7:0]         s2;
        logic [7:0]         s3;
        logic               busy;
        logic               done;
        logic               refused;
        logic [7:0]         rdata;
        logic               erased;
        logic               supply_en;
        logic               ce_n;
        logic               oe_n;
        logic               we_n;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         dq;
        logic               dq_oe;
    } state_t;
    state_t st_r;
    state_t st_nxt;
    // ============================================================
    // Sequence table: what bus cycle each step of an operation is
    function automatic logic step_is_read(input op_t op, input logic step);
        step_is_read = step && (op == OP_READ || op == OP_READ_ID
                                || op == OP_ERASE_CHECK || op == OP_PROGRAM_CHECK);
    endfunction
    function automatic logic [7:0] step_code(input op_t op, input logic step,
                                             input logic [7:0] udata);
        logic [7:0] c;
        c = `CMD_READ_ARRAY;
        case (op)
            OP_READ:          c = `CMD_READ_ARRAY;
            OP_READ_ID:       c = `CMD_READ_IDENT;
            OP_ERASE:         c = `CMD_ERASE;
            OP_ERASE_CHECK:   c = `CMD_ERASE_CHECK;
            OP_PROGRAM:       c = step ? udata : `CMD_PROGRAM;
            OP_PROGRAM_CHECK: c = `CMD_PROGRAM_CHECK;
            OP_RESET:         c = `CMD_RESET;
            default:          c = `CMD_READ_ARRAY;
        endcase
        step_code = c;
    endfunction
    function automatic logic [ADDR_W-1:0] step_addr(input op_t op, input logic step,
                                                    input logic [ADDR_W-1:0] ua);
        logic [ADDR_W-1:0] a;
        a = '0;
        case (op)
            OP_READ:        a = step ? ua : '0;
            OP_READ_ID:     a = step ? {{(ADDR_W-1){1'b0}}, ua[0]} : '0;
            OP_ERASE_CHECK: a = ua;
            OP_PROGRAM:     a = step ? ua : '0;
            default:        a = '0;
        endcase
        step_addr = a;
    endfunction
    // ============================================================
    // Next-state logic
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.refused = 1'b0;
        // Three-stage input sync; data is taken only when stages 2 and 3 agree
        st_nxt.s1 = dq_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        case (st_r.phase)
            ST_IDLE:
            begin
                // Supply may only switch between operations; a taken command keeps it on
                st_nxt.supply_en = (req_valid && st_r.supply_en && supply_ok) || supply_request;
                st_nxt.ce_n = 1'b1;
                st_nxt.oe_n = 1'b1;
                st_nxt.we_n = 1'b1;
                st_nxt.dq_oe = 1'b0;
                if (req_valid)
                begin
                    st_nxt.op = req_op;
                    st_nxt.uaddr = req_addr;
                    st_nxt.udata = req_data;
                    if (!(st_r.supply_en && supply_ok))
                    begin
                        // Without supply only plain array reads make sense
                        if (req_op == OP_READ)
                        begin
                            st_nxt.step = 1'b1;
                            st_nxt.phase = ST_SETUP;
                            st_nxt.busy = 1'b1;
                            st_nxt.cnt = SETUP_N;
                        end
                        else
                        begin
                            st_nxt.refused = 1'b1;
                            st_nxt.done = 1'b1;
                        end
                    end
                    else
                    begin
                        st_nxt.step = 1'b0;
                        st_nxt.phase = ST_SETUP;
                        st_nxt.busy = 1'b1;
                        st_nxt.cnt = SETUP_N;
                    end
                end
            end
            ST_SETUP:
            begin
                // Address settles with chip select low before any strobe
                st_nxt.ce_n = 1'b0;
                st_nxt.addr = step_addr(st_r.op, st_r.step, st_r.uaddr);
                if (st_r.cnt <= 8'h01)
                begin
                    if (step_is_read(st_r.op, st_r.step))
                    begin
                        st_nxt.oe_n = 1'b0;
                        st_nxt.cnt = ACCESS_N;
                        st_nxt.phase = ST_READ;
                    end
                    else
                    begin
                        // Data only driven while output gate is high
                        st_nxt.dq = step_code(st_r.op, st_r.step, st_r.udata);
                        st_nxt.dq_oe = 1'b1;
                        st_nxt.we_n = 1'b0;
                        st_nxt.cnt = STROBE_N;
                        st_nxt.phase = ST_STROBE;
                    end
                end
                else
                begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end
            ST_STROBE:
            begin
                if (st_r.cnt <= 8'h01)
                begin
                    // Rising edge latches data and starts erase or program
                    st_nxt.we_n = 1'b1;
                    st_nxt.cnt = HOLD_N;
                    st_nxt.phase = ST_HOLD;
                end
                else
                begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end
            ST_HOLD:
            begin
                if (st_r.cnt <= 8'h01)
                begin
                    // Deselect between cycles; a running pulse keeps going
                    st_nxt.dq_oe = 1'b0;
                    st_nxt.ce_n = 1'b1;
                    if (st_r.step)
                    begin
                        st_nxt.phase = ST_FINISH;
                    end
                    else
                    begin
                        st_nxt.step = 1'b1;
                        st_nxt.cnt = SETUP_N;
                        st_nxt.phase = ST_SETUP;
                    end
                end
                else
                begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end
            ST_READ:
            begin
                if (st_r.cnt <= 8'h01 && st_r.s2 == st_r.s3)
                begin
                    st_nxt.rdata = st_r.s3;
                    st_nxt.erased = (st_r.s3 == `ERASED_BYTE);
                    st_nxt.oe_n = 1'b1;
                    st_nxt.ce_n = 1'b1;
                    st_nxt.phase = ST_FINISH;
                end
                else if (st_r.cnt > 8'h01)
                begin
                    st_nxt.cnt = st_r.cnt - 8'h01;
                end
            end
            ST_FINISH:
            begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.phase = ST_IDLE;
            end
            default:
            begin
                st_nxt.phase = ST_IDLE;
            end
        endcase
    end
    // ============================================================
    // State register
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= '{phase: ST_IDLE, op: OP_READ, ce_n: 1'b1, oe_n: 1'b1,
                      we_n: 1'b1, default: '0};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    // ============================================================
    // Outputs straight from the state flops
    assign busy_r       = st_r.busy;
    assign done_r       = st_r.done;
    assign refused_r    = st_r.refused;
    assign rdata_r      = st_r.rdata;
    assign erased_r     = st_r.erased;
    assign supply_en_r  = st_r.supply_en;
    assign chip_sel_n_r = st_r.ce_n;
    assign out_gate_n_r = st_r.oe_n;
    assign write_n_r    = st_r.we_n;
    assign addr_r       = st_r.addr;
    assign dq_out_r     = st_r.dq;
    assign dq_oe_r      = st_r.dq_oe;
endmodule

`default_nettype wire

// ==== flash_host_checker.sv ====
`default_nettype none

// ============================================================
// Pin sequencing checks on the flash host
module flash_host_checker
#(
    parameter int ADDR_W = 18
)
(
    // Clock, reset, requests
    input wire logic                ref_clk,
    input wire logic                nrst,
    input wire logic                req_valid,
    input wire flash_host_pkg::op_t req_op,
    input wire logic                supply_ok,
    // Answers
    input wire logic                busy_r,
    input wire logic                done_r,
    input wire logic                refused_r,
    // Device pins
    input wire logic                supply_en_r,
    input wire logic                chip_sel_n_r,
    input wire logic                out_gate_n_r,
    input wire logic                write_n_r,
    input wire logic [ADDR_W-1:0]   addr_r,
    input wire logic [7:0]          dq_out_r,
    input wire logic                dq_oe_r
);
    timeunit 1ns;
    timeprecision 1ns;
    import flash_host_pkg::*;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    // Request taken at this edge, and whether a command may proceed
    wire logic take  = req_valid && !busy_r && !done_r;
    wire logic armed = supply_en_r && supply_ok;

    // ============================================================
    // Assertions
    write_sel_a: assert property (!write_n_r |-> !chip_sel_n_r && out_gate_n_r)
        else $error("strobe without select");
    supply_gate_a: assert property (!write_n_r |-> supply_en_r)
        else $error("strobe without supply");
    strobe_len_a: assert property ($fell(write_n_r) |-> ##1 !write_n_r ##1 write_n_r)
        else $error("strobe not two cycles");
    addr_hold_a: assert property (
        !write_n_r && !$past(write_n_r) |-> $stable(addr_r) && $stable(dq_out_r))
        else $error("bus moved under strobe");
    data_hold_a: assert property (
        $rose(write_n_r) |-> dq_oe_r && !chip_sel_n_r && $stable(dq_out_r))
        else $error("data not held at strobe rise");
    read_gate_a: assert property (!out_gate_n_r |-> !chip_sel_n_r && !dq_oe_r)
        else $error("gate open without select or with host driving");
    idle_float_a: assert property (
        chip_sel_n_r |-> write_n_r && out_gate_n_r && !dq_oe_r)
        else $error("activity while deselected");
    refuse_cmd_a: assert property (
        take && req_op != OP_READ && !armed |=> refused_r && done_r)
        else $error("command not refused");
    two_write_a: assert property (
        take && armed && req_op inside {OP_ERASE, OP_PROGRAM, OP_RESET}
        |-> ##12 done_r && !refused_r)
        else $error("two-write op length wrong");

    cover property (take && armed && req_op == OP_ERASE);
    cover property (refused_r);
    cover property (!out_gate_n_r && supply_en_r);
endmodule

`default_nettype wire

// ==== flash_device_model.sv ====
`default_nettype none

// ============================================================
// Behavioural flash device: command latch, small array, read mux
module flash_device_model
#(
    parameter logic [7:0] MFR_CODE = 8'hA5, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'h3C, // Arbitrary value
    parameter int         ADDR_W   = 18
)
(
    // Supply and controls
    input  wire logic              supply_on,
    input  wire logic              identifier_high_voltage,
    input  wire logic              ce_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    // Address and data
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        din,
    output logic      [7:0]        dout
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef enum logic [3:0] {M_RD, M_ID, M_ESET, M_ERS, M_ECHK, M_PSET, M_PRG, M_PCHK, M_RST}
        mode_t;
    mode_t      mode = M_RD;
    logic [7:0] mem [16];
    logic [3:0] lat_a = 4'h0;
    logic [3:0] chk_a = 4'h0;
    logic [3:0] prg_a = 4'h0;
    logic [7:0] rd;

    // Only 16 bytes kept; upper address bits alias
    initial
    begin
        for (int i = 0; i < 16; i++)
            mem[i] = 8'h10 + 8'(i);
    end

    function automatic mode_t decode(input logic [7:0] d);
        case (d)
            8'h90:   return M_ID;
            8'h20:   return M_ESET;
            8'hA0:   return M_ECHK;
            8'h40:   return M_PSET;
            8'hC0:   return M_PCHK;
            8'hFF:   return M_RST;
            default: return M_RD;
        endcase
    endfunction

    // Address taken at the falling strobe edge
    always @(negedge we_n)
        if (!ce_n)
            lat_a <= addr[3:0];

    // Command latch; deselect leaves a running operation alone
    always @(posedge we_n or negedge supply_on)
    begin
        if (!supply_on)
            mode <= M_RD;
        else if (!ce_n && mode == M_ESET && din == 8'h20)
        begin
            for (int i = 0; i < 16; i++)
                mem[i] <= 8'hFF;
            mode <= M_ERS;
        end
        else if (!ce_n && mode == M_PSET)
        begin
            mem[lat_a] <= mem[lat_a] & din;
            prg_a <= lat_a;
            mode <= M_PRG;
        end
        else if (!ce_n && mode == M_RST && din == 8'hFF)
            mode <= M_RD;
        // A stopped pulse leaves the part idle until its own verify or a reset
        else if (!ce_n && (mode == M_ERS || mode == M_PRG) && din != 8'hFF
                 && din != ((mode == M_ERS) ? 8'hA0 : 8'hC0))
            mode <= mode;
        else if (!ce_n)
        begin
            mode <= decode(din);
            chk_a <= lat_a;
        end
    end

    // Read mux; a released bus shows the inverse so stale data never matches
    // A raised identifier voltage on the address pin overrides the latched command
    always_comb
        if (identifier_high_voltage)
            rd = addr[0] ? DEV_CODE : MFR_CODE;
        else
            case (mode)
                M_ID:    rd = addr[0] ? DEV_CODE : MFR_CODE;
                M_ECHK:  rd = mem[chk_a];
                M_PCHK:  rd = mem[prg_a];
                default: rd = mem[addr[3:0]];
            endcase
    assign dout = (!ce_n && !oe_n) ? rd : ~rd;
endmodule

`default_nettype wire

// ==== testbench.sv ====
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import flash_host_pkg::*;

    localparam int         AW  = 18;
    localparam logic [7:0] MFR = 8'hA5; // Arbitrary value
    localparam logic [7:0] DEV = 8'h3C; // Arbitrary value

    // ============================================================
    // Stimulus, answers and pins
    logic          ref_clk = 1'b0;
    logic          nrst = 1'b0;
    logic          req_valid = 1'b0;
    op_t           req_op = OP_READ;
    logic [AW-1:0] req_addr = '0;
    logic [7:0]    req_data = 8'h00;
    logic          supply_request = 1'b0;
    logic          supply_ok = 1'b1;
    logic          identifier_high_voltage = 1'b0;
    logic          busy_r, done_r, refused_r, erased_r, supply_en_r;
    logic          chip_sel_n_r, out_gate_n_r, write_n_r, dq_oe_r;
    logic [7:0]    rdata_r, dq_out_r, dev_q;
    logic [AW-1:0] addr_r;
    int            err_count = 0;
    int            check_count = 0;
    // Host owns dq only while its enable is up
    wire logic [7:0] dq_in = dq_oe_r ? dq_out_r : dev_q;

    flash_host #(.ADDR_W(AW)) flash_host_inst
    (
        .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .supply_request(supply_request),
        .supply_ok(supply_ok), .busy_r(busy_r), .done_r(done_r), .refused_r(refused_r),
        .rdata_r(rdata_r), .erased_r(erased_r), .supply_en_r(supply_en_r),
        .chip_sel_n_r(chip_sel_n_r), .out_gate_n_r(out_gate_n_r), .write_n_r(write_n_r),
        .addr_r(addr_r), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r), .dq_in(dq_in)
    );

    flash_device_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .ADDR_W(AW)) flash_device_model_inst
    (
        .supply_on(supply_en_r), .ce_n(chip_sel_n_r), .oe_n(out_gate_n_r),
        .identifier_high_voltage(identifier_high_voltage),
        .we_n(write_n_r), .addr(addr_r), .din(dq_out_r), .dout(dev_q)
    );

    initial
        forever #25 ref_clk = ~ref_clk;

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One request held across one rising edge, then a bounded wait for done
    task automatic run(input op_t op, input logic [AW-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(negedge ref_clk);
        req_valid = 1'b1;
        req_op = op;
        req_addr = a;
        req_data = d;
        @(negedge ref_clk);
        req_valid = 1'b0;
        while (done_r !== 1'b1 && n < 60)
        begin
            @(negedge ref_clk);
            n++;
        end
        cmp({6'h0, busy_r, done_r}, 8'h01);
    endtask

    // Supply follows the request only while idle, so let it settle
    task automatic supply(input logic on, input logic ok);
        supply_request = on;
        supply_ok = ok;
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic t_reset_values();
        cmp({4'h0, chip_sel_n_r, out_gate_n_r, write_n_r, dq_oe_r}, 8'h0E);
        cmp({7'h0, supply_en_r}, 8'h00);
    endtask

    task automatic t_protected();
        run(OP_READ, 18'h3, 8'h00);
        cmp(rdata_r, 8'h13);
        run(OP_ERASE, 18'h0, 8'h00);
        cmp({7'h0, refused_r}, 8'h01);
        run(OP_READ, 18'h3, 8'h00);
        cmp(rdata_r, 8'h13);
    endtask

    task automatic t_lockout();
        supply(1'b1, 1'b0);
        run(OP_PROGRAM, 18'h1, 8'h00);
        cmp({7'h0, refused_r}, 8'h01);
        supply(1'b1, 1'b1);
    endtask

    task automatic t_ident();
        run(OP_READ_ID, 18'h0, 8'h00);
        cmp(rdata_r, MFR);
        run(OP_READ_ID, 18'h1, 8'h00);
        cmp(rdata_r, DEV);
        supply(1'b0, 1'b1);
        identifier_high_voltage = 1'b1;
        run(OP_READ, 18'h0, 8'h00);
        cmp(rdata_r, MFR);
        run(OP_READ, 18'h1, 8'h00);
        cmp(rdata_r, DEV);
        identifier_high_voltage = 1'b0;
        run(OP_READ, 18'h0, 8'h00);
        cmp(rdata_r, 8'h10);
        supply(1'b1, 1'b1);
    endtask

    task automatic t_erase();
        run(OP_ERASE, 18'h0, 8'h00);
        run(OP_ERASE_CHECK, 18'h7, 8'h00);
        cmp(rdata_r, 8'hFF);
        cmp({7'h0, erased_r}, 8'h01);
    endtask

    // Verify must use the programmed byte, not the address offered with it
    task automatic t_program();
        run(OP_PROGRAM, 18'h2, 8'h5A);
        run(OP_PROGRAM_CHECK, 18'h5, 8'h00);
        cmp(rdata_r, 8'h5A);
        run(OP_ERASE_CHECK, 18'h2, 8'h00);
        cmp({erased_r, rdata_r[6:0]}, 8'h5A);
        run(OP_READ, 18'h5, 8'h00);
        cmp(rdata_r, 8'hFF);
    endtask

    task automatic t_reset_cmd();
        run(OP_RESET, 18'h0, 8'h00);
        cmp({7'h0, refused_r}, 8'h00);
        run(OP_READ, 18'h2, 8'h00);
        cmp(rdata_r, 8'h5A);
    endtask

    task automatic summarize();
        if (err_count == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Seventeen operations of under 30 cycles fit well inside this span
    initial
    begin
        #200000;
        err_count++;
        summarize();
    end

    initial
    begin
        repeat (8) @(negedge ref_clk);
        nrst = 1'b1;
        t_reset_values();
        t_protected();
        t_lockout();
        t_ident();
        t_erase();
        t_program();
        t_reset_cmd();
        summarize();
    end
endmodule

bind flash_host flash_host_checker #(.ADDR_W(ADDR_W)) flash_host_checker_inst
(
    .ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid), .req_op(req_op),
    .supply_ok(supply_ok), .busy_r(busy_r), .done_r(done_r), .refused_r(refused_r),
    .supply_en_r(supply_en_r), .chip_sel_n_r(chip_sel_n_r), .out_gate_n_r(out_gate_n_r),
    .write_n_r(write_n_r), .addr_r(addr_r), .dq_out_r(dq_out_r), .dq_oe_r(dq_oe_r)
);

`default_nettype wire
